// [sim/owc_checker.sv]
`timescale 1ns/10ps

module owc_checker (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic sleep_i,
   input wire owc_pkg::owc_src_t sys_src_i,
   input wire owc_pkg::owc_osc_t osc_en_o,
   input wire owc_pkg::owc_osc_t osc_ready_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_ack_late: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_sleep_halt: assert property (
      sleep_i |=> osc_en_o == '0)
      else $error("oscillator runs in sleep");
   a_ready_drop: assert property (
      (osc_ready_o & ~osc_en_o & ~$past(osc_en_o)) == '0)
      else $error("ready while stopped");
   a_ifast_wait: assert property (
      $rose(osc_ready_o.ifast) |-> $past(osc_en_o.ifast, 56))
      else $error("internal ready early");
   a_fcry_wait: assert property (
      $rose(osc_ready_o.fcry) |-> $past(osc_en_o.fcry, 300))
      else $error("fast crystal ready early");
   a_scry_wait: assert property (
      $rose(osc_ready_o.scry) |-> $past(osc_en_o.scry, 300))
      else $error("slow crystal ready early");
   a_boot_on: assert property (
      !$past(reset_n_i) && !sleep_i |=> osc_en_o.ifast)
      else $error("internal oscillator off at boot");
   a_src_kept: assert property (
      osc_en_o[sys_src_i] && !sleep_i |=> osc_en_o[$past(sys_src_i)])
      else $error("clock source stopped");
endmodule // owc_checker

bind owc_top owc_checker i_owc_checker (.core_clk_i, .reset_n_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_i, .sys_src_i, .osc_en_o,
   .osc_ready_o);

// [sim/owc_osc_model.sv]
`timescale 1ns/10ps

module owc_osc_model (
   input wire owc_pkg::owc_osc_t osc_en_i,
   output owc_pkg::owc_osc_t osc_clk_o
);
   // A stopped cell rests low, as an external clock halted at ground.
   initial osc_clk_o = '0;
   always #20 osc_clk_o.ifast = osc_en_i.ifast & ~osc_clk_o.ifast;
   always #15 osc_clk_o.fcry = osc_en_i.fcry & ~osc_clk_o.fcry;
   always #25 osc_clk_o.scry = osc_en_i.scry & ~osc_clk_o.scry;
endmodule // owc_osc_model

// [sim/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
   localparam logic [17:0] CTRL_A = 18'h14184;
   localparam logic [17:0] STAT_A = 18'h141c0;
   logic core_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic sleep_i;
   logic [17:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   owc_pkg::owc_src_t sys_src_i;
   owc_pkg::owc_osc_t osc_clk_i, osc_en_o, osc_ready_o;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 32'hdfe6;
   logic [7:0] d, m;

   owc_top i_owc_top (.core_clk_i, .reset_n_i, .clk_en_i(1'b1), .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .sleep_i, .sys_src_i, .osc_clk_i, .osc_en_o, .osc_ready_o);
   owc_osc_model i_owc_osc_model (.osc_en_i(osc_en_o), .osc_clk_o(osc_clk_i));

   task automatic check(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic bus(input logic we, input logic [17:0] a,
      input logic [7:0] dt, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge core_clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
         {2'b11, we, a, s, 24'h0, dt};
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      check("ack", 32'(n), 32'h2);
   endtask

   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00, 4'h1);
   endtask

   // Oscillator phase is free running, so allow one period of slack.
   task automatic meas(input int b, input int n, input int p);
      int c;
      c = 0;
      while (osc_ready_o[b] !== 1'b1 && c < n * p + p + 20) begin
         @(posedge core_clk_i);
         c++;
      end
      check("wait", 32'(c >= (n - 1) * p && c <= n * p + 8), 32'h1);
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // Full run needs about 18000 cycles; this leaves twice that.
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end

   always @(posedge core_clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check("rdata", wb_dat_o, exp_q.pop_front());
   end

   initial begin
      {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      sys_src_i = owc_pkg::OWC_SRC_IFAST;
      repeat (8) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      fork
         meas(0, 64, 8);
         begin
            rd(CTRL_A, 8'h04);
            rd(18'h00100, 8'h00);
            check("en", {29'h0, osc_en_o}, 32'h1);
         end
      join
      bus(1'b1, CTRL_A, 8'h06, 4'h1);
      meas(2, 256, 10);
      sys_src_i <= owc_pkg::OWC_SRC_SCRY;
      for (int w = 0; w < 4; w++) begin
         bus(1'b1, CTRL_A, {w[1:0], w[1:0], 4'h2}, 4'h1);
         repeat (4) @(posedge core_clk_i);
         check("en", {29'h0, osc_en_o}, 32'h4);
         bus(1'b1, CTRL_A, {w[1:0], w[1:0], 4'h7}, 4'h1);
         fork
            meas(0, 64 >> w, 8);
            meas(1, 1024 >> w, 6);
         join
         rd(CTRL_A, {w[1:0], w[1:0], 4'h7});
      end
      sleep_i <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      check("rdy", {29'h0, osc_ready_o}, 32'h0);
      rd(CTRL_A, 8'hf7);
      rd(STAT_A, 8'h18);
      sleep_i <= 1'b0;
      fork
         meas(0, 8, 8);
         meas(1, 128, 6);
         meas(2, 256, 10);
      join
      rd(STAT_A, 8'h0b);
      bus(1'b1, CTRL_A, 8'h00, 4'he);
      bus(1'b1, 18'h00100, 8'h00, 4'h1);
      rd(CTRL_A, 8'hf7);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, CTRL_A, 8'h07, 4'h1);
         sys_src_i <= owc_pkg::owc_src_t'(k);
         d = 8'($random(seed));
         m = (k == 0) ? 8'h04 : 8'h01 << (k - 1);
         bus(1'b1, CTRL_A, d, 4'h1);
         rd(CTRL_A, (d | m) & 8'hf7);
      end
      end_sim;
   end
endmodule // tb_top

// [verilog/owc_consts.svh]
`ifndef OWC_CONSTS_SVH
`define OWC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define OWC_CTRL_IDX 16'h5061
`define OWC_STAT_IDX 16'h5070

// Control register reset value: internal fast oscillator on, waits longest.
`define OWC_CTRL_RST 8'h04

// Register data width in the low byte lane.
`define OWC_REG_W 8

// Control register field positions.
`define OWC_FCRY_EN_BIT 0
`define OWC_SCRY_EN_BIT 1
`define OWC_IFAST_EN_BIT 2
`define OWC_FCRY_WAIT_LO 4
`define OWC_FCRY_WAIT_HI 5
`define OWC_IFAST_WAIT_LO 6
`define OWC_IFAST_WAIT_HI 7

// Wait field encodings.
`define OWC_WSEL_0 2'h0
`define OWC_WSEL_1 2'h1
`define OWC_WSEL_2 2'h2
`define OWC_WSEL_3 2'h3

// Stabilization counts in cycles of the oscillator being started.
`define OWC_IFAST_WAIT_0 11'h040
`define OWC_IFAST_WAIT_1 11'h020
`define OWC_IFAST_WAIT_2 11'h010
`define OWC_IFAST_WAIT_3 11'h008
`define OWC_FCRY_WAIT_0 11'h400
`define OWC_FCRY_WAIT_1 11'h200
`define OWC_FCRY_WAIT_2 11'h100
`define OWC_FCRY_WAIT_3 11'h080
`define OWC_SCRY_WAIT 11'h100

// Width of the stabilization counters.
`define OWC_CNT_W 11

`endif

// [verilog/owc_pkg.sv]
package owc_pkg;

   // Oscillator currently driving the system clock, from the select stage.
   typedef enum logic [1:0] {
      OWC_SRC_IFAST,
      OWC_SRC_FCRY,
      OWC_SRC_SCRY
   } owc_src_t;

   // One bit per oscillator.
   typedef struct packed {
      logic scry;
      logic fcry;
      logic ifast;
   } owc_osc_t;

   // Control register layout, bit 7 first.
   typedef struct packed {
      logic [1:0] ifast_wait;
      logic [1:0] fcry_wait;
      logic reserved;
      logic ifast_en;
      logic scry_en;
      logic fcry_en;
   } owc_ctrl_t;

   // Status register layout, bit 7 first.
   typedef struct packed {
      logic [2:0] reserved;
      logic sleep;
      logic [1:0] src;
      logic fcry_rdy;
      logic ifast_rdy;
   } owc_stat_t;

endpackage

// [verilog/owc_stab_cnt.sv]
`timescale 1ns/10ps
`include "owc_consts.svh"

module owc_stab_cnt #(
   parameter int CNT_W = `OWC_CNT_W
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   input wire logic osc_lvl_i,
   input wire logic [CNT_W-1:0] target_i,
   output logic ready_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic prev;
      logic ready;
   } owc_cnt_st_t;

   owc_cnt_st_t st_r;
   owc_cnt_st_t st_nxt;

   // Counts rising edges of the synchronised oscillator level while it runs.
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = osc_lvl_i;
      if (!run_i) begin
         st_nxt.cnt = '0;
         st_nxt.ready = 1'b0;
      end else if (!st_r.ready && osc_lvl_i && !st_r.prev) begin
         st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
         if (st_r.cnt >= CNT_W'(target_i - 1'b1)) begin
            st_nxt.ready = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else if (clk_en_i) begin
         st_r <= st_nxt;
      end
   end

   assign ready_o = st_r.ready;

endmodule // owc_stab_cnt

// [verilog/owc_sync2.sv]
`timescale 1ns/10ps

module owc_sync2 #(
   parameter int W = 3
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } owc_sync_st_t;

   owc_sync_st_t st_r;
   owc_sync_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = async_i;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else if (clk_en_i) begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.sync;

endmodule // owc_sync2

// [verilog/owc_top.sv]
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`include "owc_consts.svh"

module owc_top #(
   parameter int ADR_W = 18
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sleep_i,
   input wire owc_pkg::owc_src_t sys_src_i,
   input wire owc_pkg::owc_osc_t osc_clk_i,
   output owc_pkg::owc_osc_t osc_en_o,
   output owc_pkg::owc_osc_t osc_ready_o
);

   typedef struct packed {
      owc_pkg::owc_ctrl_t ctrl;
      owc_pkg::owc_osc_t en;
      logic ack;
      logic [`OWC_REG_W-1:0] rdata;
   } owc_top_st_t;

   owc_top_st_t st_r;
   owc_top_st_t st_nxt;
   owc_pkg::owc_osc_t osc_lvl;
   owc_pkg::owc_osc_t ready;
   owc_pkg::owc_ctrl_t wr_ctrl;
   owc_pkg::owc_stat_t stat;
   logic [`OWC_CNT_W-1:0] ifast_target;
   logic [`OWC_CNT_W-1:0] fcry_target;
   logic req;
   logic wr_ack;
   logic hit_ctrl;
   logic hit_stat;

   function automatic logic [`OWC_CNT_W-1:0] ifast_wait(
      input logic [1:0] sel
   );
      logic [`OWC_CNT_W-1:0] n;
      unique case (sel)
         `OWC_WSEL_3: n = `OWC_IFAST_WAIT_3;
         `OWC_WSEL_2: n = `OWC_IFAST_WAIT_2;
         `OWC_WSEL_1: n = `OWC_IFAST_WAIT_1;
         `OWC_WSEL_0: n = `OWC_IFAST_WAIT_0;
      endcase
      return n;
   endfunction

   function automatic logic [`OWC_CNT_W-1:0] fcry_wait(
      input logic [1:0] sel
   );
      logic [`OWC_CNT_W-1:0] n;
      unique case (sel)
         `OWC_WSEL_3: n = `OWC_FCRY_WAIT_3;
         `OWC_WSEL_2: n = `OWC_FCRY_WAIT_2;
         `OWC_WSEL_1: n = `OWC_FCRY_WAIT_1;
         `OWC_WSEL_0: n = `OWC_FCRY_WAIT_0;
      endcase
      return n;
   endfunction

   // Oscillator outputs arrive from analog cells, outside this clock domain.
   owc_sync2 #(
      .W(3)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .async_i(osc_clk_i),
      .sync_o(osc_lvl)
   );

   assign ifast_target = ifast_wait(st_r.ctrl.ifast_wait);
   assign fcry_target = fcry_wait(st_r.ctrl.fcry_wait);

   // Each counter restarts whenever its oscillator stops, so every start
   // waits the full count, including the start after reset release.
   owc_stab_cnt #(
      .CNT_W(`OWC_CNT_W)
   ) u_ifast_cnt (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .run_i(st_r.en.ifast),
      .osc_lvl_i(osc_lvl.ifast),
      .target_i(ifast_target),
      .ready_o(ready.ifast)
   );

   owc_stab_cnt #(
      .CNT_W(`OWC_CNT_W)
   ) u_fcry_cnt (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .run_i(st_r.en.fcry),
      .osc_lvl_i(osc_lvl.fcry),
      .target_i(fcry_target),
      .ready_o(ready.fcry)
   );

   owc_stab_cnt #(
      .CNT_W(`OWC_CNT_W)
   ) u_scry_cnt (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .run_i(st_r.en.scry),
      .osc_lvl_i(osc_lvl.scry),
      .target_i(`OWC_SCRY_WAIT),
      .ready_o(ready.scry)
   );

   assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
   assign wr_ack = wb_cyc_i && wb_stb_i && st_r.ack;
   assign hit_ctrl = (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(`OWC_CTRL_IDX));
   assign hit_stat = (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(`OWC_STAT_IDX));

   always_comb begin
      stat = '0;
      stat.sleep = sleep_i;
      stat.src = sys_src_i;
      stat.fcry_rdy = ready.fcry;
      stat.ifast_rdy = ready.ifast;
   end

   // A write cannot clear the enable bit of the oscillator now feeding the system.
   always_comb begin
      wr_ctrl = owc_pkg::owc_ctrl_t'(wb_dat_i[`OWC_REG_W-1:0]);
      wr_ctrl.reserved = 1'b0;
      if (sys_src_i == owc_pkg::OWC_SRC_IFAST) begin
         wr_ctrl.ifast_en = 1'b1;
      end
      if (sys_src_i == owc_pkg::OWC_SRC_FCRY) begin
         wr_ctrl.fcry_en = 1'b1;
      end
      if (sys_src_i == owc_pkg::OWC_SRC_SCRY) begin
         wr_ctrl.scry_en = 1'b1;
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req;
      if (req) begin
         st_nxt.rdata = '0;
         if (hit_ctrl) begin
            st_nxt.rdata = st_r.ctrl;
         end else if (hit_stat) begin
            st_nxt.rdata = stat;
         end
      end
      // A write lands at the edge where the master sees ack, while the
      // request and its data still stand.
      if (wr_ack && hit_ctrl && wb_we_i && wb_sel_i[0]) begin
         st_nxt.ctrl = wr_ctrl;
      end
      // SLEEP overrides every enable bit but leaves the bits themselves.
      st_nxt.en.ifast = st_r.ctrl.ifast_en && !sleep_i;
      st_nxt.en.fcry = st_r.ctrl.fcry_en && !sleep_i;
      st_nxt.en.scry = st_r.ctrl.scry_en && !sleep_i;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r.ctrl <= `OWC_CTRL_RST;
         st_r.en <= '0;
         st_r.ack <= 1'b0;
         st_r.rdata <= '0;
      end else if (clk_en_i) begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o = {24'h000000, st_r.rdata};
   assign wb_ack_o = st_r.ack;
   assign osc_en_o = st_r.en;
   assign osc_ready_o = ready;

endmodule // owc_top
